// ==== timer_pkg.sv ====
// constants shared by the dual reload timer block: register map, field positions,
// reset values and widths; assumes a 32-bit apb data path with byte addresses
package timer_pkg;

  // data path and register widths
  localparam int DATA_WIDTH = 32;
  localparam int ADDR_WIDTH = 16;
  localparam int COUNT_WIDTH = 32;

  // register byte offsets
  localparam logic [15:0] MODE_OFFSET = 16'h6000;
  localparam logic [15:0] BASE0_OFFSET = 16'h6004;
  localparam logic [15:0] BASE1_OFFSET = 16'h6008;
  localparam logic [15:0] COUNT0_OFFSET = 16'h600c;
  localparam logic [15:0] COUNT1_OFFSET = 16'h6010;

  // mode register fields, one enable and one operation select per timer
  localparam int T0_ENABLE_BIT = 0;
  localparam int T0_TOGGLE_BIT = 1;
  localparam int T1_ENABLE_BIT = 3;
  localparam int T1_TOGGLE_BIT = 4;

  // reset values
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0fff_ffff;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // operation select encodings
  localparam logic OP_INTERVAL = 1'b0;
  localparam logic OP_TOGGLE = 1'b1;

  // decoded register selector
  typedef enum {
    SEL_MODE,
    SEL_BASE0,
    SEL_BASE1,
    SEL_COUNT0,
    SEL_COUNT1,
    SEL_NONE
  } reg_sel_t;

endpackage

// ==== timer_channel.sv ====
// one down-counting reload timer with its output pin and time-out request
// assumes enable and mode come from registers on the same clock as the counter
`timescale 1ns/1ps
`default_nettype none
module timer_channel #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] RESET_COUNT = '1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic toggle_mode,
  input wire logic [WIDTH-1:0] base_value,
  input wire logic count_wr,
  input wire logic [WIDTH-1:0] count_wdata,
  output logic [WIDTH-1:0] count_value,
  output logic output_pin,
  output logic timeout_irq
);

  logic enable_d_reg;
  logic [WIDTH-1:0] count_reg;
  logic pin_reg;
  logic irq_reg;
  logic start;
  logic running;
  logic expire;

  generate
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
      $error("timer_channel: WIDTH must lie in 1..32");
    end
  endgenerate

  // the first enabled cycle loads, later enabled cycles count
  assign start = enable && !enable_d_reg;
  assign running = enable && enable_d_reg;
  // R02: time-out when the count reaches zero
  assign expire = running && (count_reg == '0);

  // remember last enable so a fresh enable can be seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_d_reg <= 1'b0;
    end else begin
      enable_d_reg <= enable;
    end
  end

  // counter: software write wins, then load, reload, decrement, hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= RESET_COUNT;
    end else if (count_wr) begin
      count_reg <= count_wdata;
    // R07: load base on enable
    end else if (start) begin
      count_reg <= base_value;
    // R08 R11: reload after base+1 cycles
    end else if (expire) begin
      count_reg <= base_value;
    end else if (running) begin
      count_reg <= count_reg - 1'b1;
    end
    // R09: halted timer keeps its count, no reload
  end

  // output pin shaping per operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= 1'b0;
    // R15: low while disabled, restart low
    end else if (!enable || start) begin
      pin_reg <= 1'b0;
    // R05 R06: toggle gives half-rate square wave
    end else if (expire && toggle_mode == timer_pkg::OP_TOGGLE) begin
      pin_reg <= !pin_reg;
    // R03 R04: single-clock pulse in interval operation
    end else if (toggle_mode == timer_pkg::OP_INTERVAL) begin
      pin_reg <= expire;
    end
  end

  // R02 R05: request pulse at each time-out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= expire;
    end
  end

  assign count_value = count_reg;
  assign output_pin = pin_reg;
  assign timeout_irq = irq_reg;

endmodule
`default_nettype wire

// ==== apb_port.sv ====
// apb slave handshake: no wait states, registered read data and error answer
// assumes the master holds the request stable through the access phase
`timescale 1ns/1ps
`default_nettype none
module apb_port #(
  parameter int DATA_WIDTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic addr_valid,
  input wire logic [DATA_WIDTH-1:0] read_value,
  output logic pready,
  output logic pslverr,
  output logic [DATA_WIDTH-1:0] prdata,
  output logic write_fire
);

  logic pready_reg;
  logic pslverr_reg;
  logic [DATA_WIDTH-1:0] prdata_reg;
  logic setup;

  assign setup = psel && !penable;

  // ready rises for the first access cycle, so every transfer takes two cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !addr_valid;
    end
  end

  // read data captured in the setup cycle; stays put otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (setup) begin
      prdata_reg <= (!pwrite && addr_valid) ? read_value : '0;
    end
  end

  // a write lands only at the completing edge of a mapped access
  assign write_fire = psel && penable && pready_reg && pwrite && addr_valid;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

endmodule
`default_nettype wire

// ==== dual_reload_timer.sv ====
// top of the dual 32-bit reload timer: apb register file plus two timer channels
// assumes a single 200 mhz pclk domain and an apb master on the same clock
//
// Behaviour
// R01: two independent 32-bit timers, each interval or toggle operation
// R02: each timer raises its own request at every count-out
// R03: interval operation gives one-clock pin pulse per time-out, also the request
// R04: interval pulse rate is clock over programmed period
// R05: toggle operation inverts the pin and raises a request at each time-out
// R06: toggle output is a 50% square wave at half the interval rate
// R07: on enable the base value loads into the count, then decrements
// R08: at expiry request, reload base and keep counting unaided
// R09: halting a running timer does not reload its count
// R10: software changes a base value only while that timer is disabled; the code accepts base writes at any time
// R11: time-out lasts base value plus one clock cycles
// R12: count registers read the live count and reset to 0x0fffffff
// R13: one mode register controls both timers, resets to zero, both disabled
// R14: mode register holds an enable and operation select per timer
// R15: pin low while disabled, toggle output restarts low on enable
`timescale 1ns/1ps
`default_nettype none
module dual_reload_timer #(
  parameter int ADDR_WIDTH = timer_pkg::ADDR_WIDTH,
  parameter int COUNT_WIDTH = timer_pkg::COUNT_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [timer_pkg::DATA_WIDTH-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [timer_pkg::DATA_WIDTH-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timer0_output_pin,
  output logic timer1_output_pin,
  output logic timer0_irq,
  output logic timer1_irq
);

  localparam int DW = timer_pkg::DATA_WIDTH;

  generate
    if (ADDR_WIDTH < 15 || ADDR_WIDTH > 16) begin : g_bad_addr
      $error("dual_reload_timer: ADDR_WIDTH must be 15 or 16");
    end
    if (COUNT_WIDTH < 1 || COUNT_WIDTH > DW) begin : g_bad_count
      $error("dual_reload_timer: COUNT_WIDTH must lie in 1..32");
    end
  endgenerate

  // address decode shared by the read path and the write path
  function automatic timer_pkg::reg_sel_t decode(input logic [ADDR_WIDTH-1:0] addr);
    logic [15:0] a;
    a = 16'(addr);
    unique case (a)
      timer_pkg::MODE_OFFSET: decode = timer_pkg::SEL_MODE;
      timer_pkg::BASE0_OFFSET: decode = timer_pkg::SEL_BASE0;
      timer_pkg::BASE1_OFFSET: decode = timer_pkg::SEL_BASE1;
      timer_pkg::COUNT0_OFFSET: decode = timer_pkg::SEL_COUNT0;
      timer_pkg::COUNT1_OFFSET: decode = timer_pkg::SEL_COUNT1;
      default: decode = timer_pkg::SEL_NONE;
    endcase
  endfunction

  // merge write data into an old value under the byte strobes
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_value,
                                          input logic [DW-1:0] new_value,
                                          input logic [3:0] strobe);
    logic [DW-1:0] result;
    result = old_value;
    for (int b = 0; b < 4; b++) begin
      if (strobe[b]) begin
        result[b*8 +: 8] = new_value[b*8 +: 8];
      end
    end
    merge = result;
  endfunction

  timer_pkg::reg_sel_t sel;
  logic addr_valid;
  logic write_fire;
  logic [DW-1:0] read_value;

  logic [DW-1:0] mode_reg;
  logic [DW-1:0] mode_next;
  logic [DW-1:0] mode_merged;
  logic [COUNT_WIDTH-1:0] base_reg [2];
  logic [COUNT_WIDTH-1:0] count_value [2];
  logic [COUNT_WIDTH-1:0] count_wdata [2];
  logic count_wr [2];
  logic chan_enable [2];
  logic chan_toggle [2];
  logic chan_pin [2];
  logic chan_irq [2];

  assign sel = decode(paddr);
  assign addr_valid = (sel != timer_pkg::SEL_NONE);

  // bus handshake and answer timing live in the port module
  apb_port #(
    .DATA_WIDTH(DW)
  ) u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .addr_valid(addr_valid),
    .read_value(read_value),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .write_fire(write_fire)
  );

  // strobe merge done once, then only the kept bits are picked from it
  assign mode_merged = merge(mode_reg, pwdata, pstrb);

  // R14: only the enable and select bits are kept; the rest reads zero
  always_comb begin
    mode_next = timer_pkg::READ_ZERO;
    mode_next[timer_pkg::T0_ENABLE_BIT] = mode_merged[timer_pkg::T0_ENABLE_BIT];
    mode_next[timer_pkg::T0_TOGGLE_BIT] = mode_merged[timer_pkg::T0_TOGGLE_BIT];
    mode_next[timer_pkg::T1_ENABLE_BIT] = mode_merged[timer_pkg::T1_ENABLE_BIT];
    mode_next[timer_pkg::T1_TOGGLE_BIT] = mode_merged[timer_pkg::T1_TOGGLE_BIT];
  end

  // R13: mode register, both timers disabled from reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= timer_pkg::MODE_RESET;
    end else if (write_fire && sel == timer_pkg::SEL_MODE) begin
      mode_reg <= mode_next;
    end
  end

  assign chan_enable[0] = mode_reg[timer_pkg::T0_ENABLE_BIT];
  assign chan_toggle[0] = mode_reg[timer_pkg::T0_TOGGLE_BIT];
  assign chan_enable[1] = mode_reg[timer_pkg::T1_ENABLE_BIT];
  assign chan_toggle[1] = mode_reg[timer_pkg::T1_TOGGLE_BIT];

  // R01: two identical channels, each with its own base and count
  generate
    for (genvar i = 0; i < 2; i++) begin : g_chan
      timer_pkg::reg_sel_t base_sel;
      timer_pkg::reg_sel_t count_sel;
      assign base_sel = (i == 0) ? timer_pkg::SEL_BASE0 : timer_pkg::SEL_BASE1;
      assign count_sel = (i == 0) ? timer_pkg::SEL_COUNT0 : timer_pkg::SEL_COUNT1;

      // base value; writing it while running is tolerated but takes effect at the next reload
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          base_reg[i] <= COUNT_WIDTH'(timer_pkg::BASE_RESET);
        end else if (write_fire && sel == base_sel) begin
          base_reg[i] <= COUNT_WIDTH'(merge(DW'(base_reg[i]), pwdata, pstrb));
        end
      end

      // software may preset the live count directly
      assign count_wr[i] = write_fire && (sel == count_sel);
      assign count_wdata[i] = COUNT_WIDTH'(merge(DW'(count_value[i]), pwdata, pstrb));

      timer_channel #(
        .WIDTH(COUNT_WIDTH),
        .RESET_COUNT(COUNT_WIDTH'(timer_pkg::COUNT_RESET))
      ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .enable(chan_enable[i]),
        .toggle_mode(chan_toggle[i]),
        .base_value(base_reg[i]),
        .count_wr(count_wr[i]),
        .count_wdata(count_wdata[i]),
        .count_value(count_value[i]),
        .output_pin(chan_pin[i]),
        .timeout_irq(chan_irq[i])
      );
    end
  endgenerate

  // R12: count registers read back the live count
  always_comb begin
    unique case (sel)
      timer_pkg::SEL_MODE: read_value = mode_reg;
      timer_pkg::SEL_BASE0: read_value = DW'(base_reg[0]);
      timer_pkg::SEL_BASE1: read_value = DW'(base_reg[1]);
      timer_pkg::SEL_COUNT0: read_value = DW'(count_value[0]);
      timer_pkg::SEL_COUNT1: read_value = DW'(count_value[1]);
      timer_pkg::SEL_NONE: read_value = timer_pkg::READ_ZERO;
    endcase
  end

  // pins and requests come straight from channel flip-flops
  assign timer0_output_pin = chan_pin[0];
  assign timer1_output_pin = chan_pin[1];
  assign timer0_irq = chan_irq[0];
  assign timer1_irq = chan_irq[1];

endmodule
`default_nettype wire

// ==== dual_reload_timer_assertions.sv ====
// checker for the dual reload timer: apb answer timing and timer pin/request timing
// assumes full-word writes to mode and base0, and base0 changed only while disabled
`timescale 1ns/1ps
`default_nettype none
module dual_reload_timer_assertions #(
  parameter int ADDR_WIDTH = 16,
  parameter int COUNT_WIDTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer0_output_pin,
  input wire logic timer1_output_pin,
  input wire logic timer0_irq,
  input wire logic timer1_irq
);
  logic [31:0] mode_sh;
  logic [31:0] base0_sh;
  logic [31:0] gap0;
  wire logic wr_ok = psel && penable && pready && pwrite && !pslverr;
  wire logic en0 = mode_sh[timer_pkg::T0_ENABLE_BIT];
  wire logic tg0 = mode_sh[timer_pkg::T0_TOGGLE_BIT];
  wire logic en1 = mode_sh[timer_pkg::T1_ENABLE_BIT];
  wire logic tg1 = mode_sh[timer_pkg::T1_TOGGLE_BIT];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of mode and base0, taken at the completing apb edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sh <= 32'h0000_0000;
      base0_sh <= 32'h0000_0000;
    end else if (wr_ok && paddr == timer_pkg::MODE_OFFSET) begin
      mode_sh <= pwdata;
    end else if (wr_ok && paddr == timer_pkg::BASE0_OFFSET) begin
      base0_sh <= pwdata;
    end
  end
  // cycles since last request; all ones while idle so the first period lines up too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap0 <= 32'hffff_ffff;
    end else if (!en0) begin
      gap0 <= 32'hffff_ffff;
    end else if (timer0_irq) begin
      gap0 <= 32'h0000_0001;
    end else begin
      gap0 <= gap0 + 32'h0000_0001;
    end
  end
  a_pready_one_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_pin0_low_off: assert property (!en0 && !$past(en0) |-> !timer0_output_pin)
    else $error("timer0 pin high while disabled");
  a_pin1_low_off: assert property (!en1 && !$past(en1) |-> !timer1_output_pin)
    else $error("timer1 pin high while disabled");
  a_irq0_quiet_off: assert property (!en0 && !$past(en0) |-> !timer0_irq)
    else $error("timer0 request while disabled");
  a_interval_pin_irq: assert property (en0 && !tg0 && $past(en0 && !tg0) |-> timer0_output_pin == timer0_irq)
    else $error("interval pin differs from request");
  a_toggle_irq_flip: assert property (en1 && tg1 && $past(en1 && tg1)
    |-> timer1_irq == (timer1_output_pin != $past(timer1_output_pin)))
    else $error("toggle request not at pin inversion");
  a_period_base0: assert property (timer0_irq |-> gap0 == base0_sh + 32'h0000_0001)
    else $error("timer0 period not base plus one");
  c_interval: cover property (timer0_irq && timer0_output_pin);
  c_toggle: cover property (timer1_irq && timer1_output_pin);
  c_unmapped: cover property (pslverr);
endmodule
`default_nettype wire

// ==== dual_reload_timer_tb_top.sv ====
// self-checking bench for the dual reload timer: register rows, then timer and reset cases
// assumes the checker file is compiled alongside and bound below
`timescale 1ns/1ps
`default_nettype none
module dual_reload_timer_tb_top;
  typedef struct {logic [15:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] x; logic e;} row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic timer0_output_pin, timer1_output_pin, timer0_irq, timer1_irq;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd, held;
  logic [3:0] pstrb;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  row_t rows [6];
  dual_reload_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer0_output_pin(timer0_output_pin),
    .timer1_output_pin(timer1_output_pin), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", nm, x, g);
      num_errors++;
    end
  endtask
  // one apb transfer; answer taken at the rising edge that sees pready, released right after it
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) num_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // waits for the watched signal high, then counts cycles until it equals tgt
  task span(input logic sel, input logic tgt, output int cnt);
    int k;
    k = 0;
    do begin @(negedge pclk); k++; end while ((sel ? timer1_output_pin : timer0_irq) !== 1'b1 && k < 200);
    cnt = 0;
    do begin @(negedge pclk); cnt++; end while ((sel ? timer1_output_pin : timer0_irq) !== tgt && cnt < 200);
  endtask
  // watchdog: the whole run is well under a thousand cycles, far below the 20000-cycle limit
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    report_and_stop;
  end
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0000; pwdata = 32'h0000_0000;
    pstrb = 4'h0; presetn = 1'b0;
    rows = '{'{16'h6000, 32'hffff_ffe4, 4'hf, 32'h0000_0000, 1'b0},
      '{16'h6004, 32'h0000_0005, 4'hf, 32'h0000_0005, 1'b0},
      '{16'h6008, 32'haabb_ccdd, 4'hf, 32'haabb_ccdd, 1'b0},
      '{16'h6008, 32'h1122_3344, 4'h1, 32'haabb_cc44, 1'b0},
      '{16'h600c, 32'h0000_0009, 4'hf, 32'h0000_0009, 1'b0},
      '{16'h6014, 32'h1234_5678, 4'hf, 32'h0000_0000, 1'b1}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
      chk("write err", {31'h0, rows[i].e}, {31'h0, er});
      apb(1'b0, rows[i].a, 32'h0000_0000, 4'hf);
      chk("read data", rows[i].x, rd);
      chk("read err", {31'h0, rows[i].e}, {31'h0, er});
    end
    $display("register rows done");
    apb(1'b1, 16'h6004, 32'h0000_0003, 4'hf);
    apb(1'b1, 16'h6000, 32'h0000_0001, 4'hf);
    span(1'b0, 1'b1, n);
    chk("t0 interval period", 32'h0000_0004, 32'(n));
    chk("t0 interval pin", 32'h0000_0001, {31'h0, timer0_output_pin});
    apb(1'b0, 16'h600c, 32'h0000_0000, 4'hf);
    chk("t0 live count", 32'h0000_0002, rd);
    apb(1'b1, 16'h6008, 32'h0000_0002, 4'hf);
    apb(1'b1, 16'h6000, 32'h0000_0019, 4'hf);
    span(1'b1, 1'b0, n);
    chk("t1 toggle half period", 32'h0000_0003, 32'(n));
    chk("t1 toggle irq", 32'h0000_0001, {31'h0, timer1_irq});
    span(1'b0, 1'b1, n);
    chk("t0 period beside t1", 32'h0000_0004, 32'(n));
    $display("timer runs done");
    apb(1'b1, 16'h6000, 32'h0000_0000, 4'hf);
    apb(1'b0, 16'h600c, 32'h0000_0000, 4'hf);
    held = rd;
    repeat (10) @(posedge pclk);
    apb(1'b0, 16'h600c, 32'h0000_0000, 4'hf);
    chk("t0 halted count", held, rd);
    apb(1'b1, 16'h6000, 32'h0000_0018, 4'hf);
    @(negedge pclk);
    chk("t1 restart low", 32'h0000_0000, {31'h0, timer1_output_pin});
    $display("halt and restart done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("reset outputs", 32'h0000_0000, {26'h0, pready, pslverr, timer0_output_pin, timer1_output_pin,
      timer0_irq, timer1_irq});
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 16'h6000 + 16'(4 * i), 32'h0000_0000, 4'hf);
      chk("reset value", (i > 2) ? timer_pkg::COUNT_RESET : 32'h0000_0000, rd);
    end
    $display("reset values done");
    report_and_stop;
  end
endmodule
bind dual_reload_timer dual_reload_timer_assertions #(.ADDR_WIDTH(ADDR_WIDTH), .COUNT_WIDTH(COUNT_WIDTH)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer0_output_pin(timer0_output_pin), .timer1_output_pin(timer1_output_pin),
  .timer0_irq(timer0_irq), .timer1_irq(timer1_irq));
`default_nettype wire
